/* File: slave_error_status_reporter_defs.vh */
// constants of the slave error status reporter
`ifndef SLAVE_ERROR_STATUS_REPORTER_DEFS_VH
`define SLAVE_ERROR_STATUS_REPORTER_DEFS_VH

// ------------------------------------------------------------
// status word offsets from the first word
// ------------------------------------------------------------
`define OFS_OUT_FLAGS_LOW 12'h008
`define OFS_IN_FLAGS_LOW 12'h009
`define OFS_WIDE_OUT_FLAGS_LOW 12'h010
`define OFS_WIDE_IN_FLAGS_LOW 12'h011
`define OFS_WIDE_OUT_FLAGS_HIGH 12'h012
`define OFS_WIDE_IN_FLAGS_HIGH 12'h013

// ------------------------------------------------------------
// field layout of a flag word
// ------------------------------------------------------------
`define ERR_FIELD_MSB 15
`define ERR_FIELD_LSB 8
`define ACT_FIELD_MSB 7
`define ACT_FIELD_LSB 0

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define FLAGS_RESET 16'h0000
`define WORD_RESET 16'h0000

// ------------------------------------------------------------
// slave population
// ------------------------------------------------------------
`define NODE_COUNT 16
`define NARROW_MASK 16'h00FF
`define WIDE_MASK 16'hFFFF

// ------------------------------------------------------------
// status area base formulas
// ------------------------------------------------------------
`define BASE_FAMILY_A 12'h7D0
`define BASE_FAMILY_B_LOW 12'h064
`define BASE_FAMILY_B_HIGH 12'h190
`define BASE_STEP 12'h00A
`define UNIT_SPLIT 4'hA
`define NARROW_LOW_LAST 4'h9
`define WIDE_LOW_LAST 4'h8
`define WIDE_HIGH_LAST 4'hE

`endif

/* File: lowest_set_finder.v */
// finds the lowest set bit of a vector
`timescale 1ns/1ps
`default_nettype none

module lowest_set_finder #(
	parameter WIDTH = 32,
	parameter IDX_W = 5
)(
	input wire [WIDTH-1:0] vec,
	output wire found,
	output wire [IDX_W-1:0] index
);

	wire [WIDTH:0] seen;
	wire [IDX_W-1:0] acc [0:WIDTH];

	assign seen[0] = 1'b0;
	assign acc[0] = {IDX_W{1'b0}};

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1)
		begin : scan
			localparam [IDX_W-1:0] POS = i;
			wire first;
			assign first = vec[i] & ~seen[i];
			assign seen[i+1] = seen[i] | vec[i];
			assign acc[i+1] = acc[i] | (first ? POS : {IDX_W{1'b0}});
		end
	endgenerate

	assign found = seen[WIDTH];
	assign index = acc[WIDTH];

endmodule

`default_nettype wire

/* File: slave_error_status_reporter.v */
// slave error lamp display and host-visible slave status words
`timescale 1ns/1ps
`default_nettype none
`include "slave_error_status_reporter_defs.vh"

module slave_error_status_reporter #(
	parameter DATA_W = 8
)(
	input wire clock,
	input wire arst_n,
	input wire clockEnable,
	input wire restart,
	input wire wideModePin,
	input wire familyPin,
	input wire [3:0] unitNumberPin,
	input wire [`NODE_COUNT-1:0] outJoin,
	input wire [`NODE_COUNT-1:0] outFault,
	input wire [`NODE_COUNT-1:0] inJoin,
	input wire [`NODE_COUNT-1:0] inFault,
	input wire rxStrobe,
	input wire [3:0] rxNode,
	input wire [DATA_W-1:0] rxData,
	input wire [3:0] inputSelect,
	output reg [DATA_W-1:0] selectedInput,
	input wire hostRead,
	input wire [11:0] hostAddr,
	output reg [15:0] hostReadData,
	output reg hostReadAck,
	output reg [11:0] statusBase,
	output reg unitValid,
	output reg comm_fault_lamp,
	output reg lampIo,
	output reg [3:0] lampNode
);

	// ------------------------------------------------------------
	// configuration switches
	// ------------------------------------------------------------
	reg [5:0] cfgMeta;
	reg [5:0] cfgSync;
	wire wideMode;
	wire family;
	wire [3:0] unitNumber;
	wire [15:0] usable;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cfgMeta <= 6'h00;
			cfgSync <= 6'h00;
		end
		else if (clockEnable)
		begin
			cfgMeta <= {wideModePin, familyPin, unitNumberPin};
			cfgSync <= cfgMeta;
		end
	end

	assign wideMode = cfgSync[5];
	assign family = cfgSync[4];
	assign unitNumber = cfgSync[3:0];
	assign usable = wideMode ? `WIDE_MASK : `NARROW_MASK;

	// ------------------------------------------------------------
	// status area base
	// ------------------------------------------------------------
	reg [11:0] next_statusBase;
	reg next_unitValid;
	wire [11:0] unitWide;
	wire [11:0] unitHigh;

	assign unitWide = {8'h00, unitNumber};
	assign unitHigh = unitWide - {8'h00, `UNIT_SPLIT};

	always @*
	begin
		next_statusBase = 12'h000;
		next_unitValid = 1'b0;
		if (!family)
		begin
			next_statusBase = `BASE_FAMILY_A + unitWide * `BASE_STEP;
			next_unitValid = 1'b1;
		end
		else if (unitNumber < `UNIT_SPLIT)
		begin
			next_statusBase = `BASE_FAMILY_B_LOW + unitWide * `BASE_STEP;
			next_unitValid = wideMode ? (unitNumber <= `WIDE_LOW_LAST)
				: (unitNumber <= `NARROW_LOW_LAST);
		end
		else
		begin
			next_statusBase = `BASE_FAMILY_B_HIGH + unitHigh * `BASE_STEP;
			next_unitValid = wideMode ? (unitNumber <= `WIDE_HIGH_LAST)
				: 1'b1;
		end
	end

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			statusBase <= 12'h000;
			unitValid <= 1'b0;
		end
		else if (clockEnable)
		begin
			statusBase <= next_statusBase;
			unitValid <= next_unitValid;
		end
	end

	// ------------------------------------------------------------
	// per-slave flags
	// ------------------------------------------------------------
	reg [15:0] outActive;
	reg [15:0] outError;
	reg [15:0] inActive;
	reg [15:0] inError;
	wire [15:0] outFaultUsed;
	wire [15:0] inFaultUsed;
	wire [15:0] next_outActive;
	wire [15:0] next_outError;
	wire [15:0] next_inActive;
	wire [15:0] next_inError;

	assign outFaultUsed = outFault & usable;
	assign inFaultUsed = inFault & usable;
	// active flags never drop on withdrawal
	assign next_outActive = outActive | (outJoin & usable);
	assign next_inActive = inActive | (inJoin & usable);
	// a rejoin clears the error; a fault in the same cycle wins
	assign next_outError = (outError & ~outJoin) | outFaultUsed;
	assign next_inError = (inError & ~inJoin) | inFaultUsed;

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			outActive <= `FLAGS_RESET;
			outError <= `FLAGS_RESET;
			inActive <= `FLAGS_RESET;
			inError <= `FLAGS_RESET;
		end
		else if (clockEnable)
		begin
			if (restart)
			begin
				outActive <= `FLAGS_RESET;
				outError <= `FLAGS_RESET;
				inActive <= `FLAGS_RESET;
				inError <= `FLAGS_RESET;
			end
			else
			begin
				outActive <= next_outActive;
				outError <= next_outError;
				inActive <= next_inActive;
				inError <= next_inError;
			end
		end
	end

	// ------------------------------------------------------------
	// held input data
	// ------------------------------------------------------------
	reg [DATA_W-1:0] heldInput [0:`NODE_COUNT-1];
	wire rxAccept;
	integer k;

	// data of a faulted slave is frozen at its last good value
	assign rxAccept = rxStrobe & usable[rxNode] & ~inError[rxNode]
		& ~inFault[rxNode];

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			for (k = 0; k < `NODE_COUNT; k = k + 1)
				heldInput[k] <= {DATA_W{1'b0}};
			selectedInput <= {DATA_W{1'b0}};
		end
		else if (clockEnable)
		begin
			if (rxAccept)
				heldInput[rxNode] <= rxData;
			selectedInput <= heldInput[inputSelect];
		end
	end

	// ------------------------------------------------------------
	// host status word read
	// ------------------------------------------------------------
	wire [11:0] wordOffset;
	reg [15:0] next_word;

	assign wordOffset = hostAddr - statusBase;

	always @*
	begin
		next_word = `WORD_RESET;
		if (unitValid)
		begin
			if (!wideMode)
			begin
				if (wordOffset == `OFS_OUT_FLAGS_LOW)
					next_word = {outError[7:0], outActive[7:0]};
				else if (wordOffset == `OFS_IN_FLAGS_LOW)
					next_word = {inError[7:0], inActive[7:0]};
			end
			else
			begin
				if (wordOffset == `OFS_WIDE_OUT_FLAGS_LOW)
					next_word = {outError[7:0], outActive[7:0]};
				else if (wordOffset == `OFS_WIDE_IN_FLAGS_LOW)
					next_word = {inError[7:0], inActive[7:0]};
				else if (wordOffset == `OFS_WIDE_OUT_FLAGS_HIGH)
					next_word = {outError[15:8], outActive[15:8]};
				else if (wordOffset == `OFS_WIDE_IN_FLAGS_HIGH)
					next_word = {inError[15:8], inActive[15:8]};
			end
		end
	end

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hostReadData <= `WORD_RESET;
			hostReadAck <= 1'b0;
		end
		else if (clockEnable)
		begin
			hostReadAck <= hostRead;
			if (hostRead)
				hostReadData <= next_word;
		end
	end

	// ------------------------------------------------------------
	// error node display
	// ------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_SHOW = 2'b10;

	reg [1:0] state;
	reg [4:0] shown;
	wire [31:0] pending;
	wire pendFound;
	wire [4:0] pendIndex;
	wire shownStillFaulty;

	// pending errors, with this cycle's new faults counted in
	assign pending = {inError | inFaultUsed, outError | outFaultUsed};
	assign shownStillFaulty = shown[4] ? inError[shown[3:0]]
		: outError[shown[3:0]];

	// lowest index wins among errors seen in the same cycle
	lowest_set_finder #(
		.WIDTH(32),
		.IDX_W(5)
	) pickFirst (
		.vec(pending),
		.found(pendFound),
		.index(pendIndex)
	);

	always @(posedge clock or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state <= ST_IDLE;
			shown <= 5'h00;
			comm_fault_lamp <= 1'b0;
			lampIo <= 1'b0;
			lampNode <= 4'h0;
		end
		else if (clockEnable)
		begin
			if (restart)
			begin
				state <= ST_IDLE;
				comm_fault_lamp <= 1'b0;
				lampIo <= 1'b0;
				lampNode <= 4'h0;
			end
			else
			begin
				case (state)
					ST_IDLE:
					begin
						if (pendFound)
						begin
							state <= ST_SHOW;
							shown <= pendIndex;
							comm_fault_lamp <= 1'b1;
							lampNode <= pendIndex[3:0];
							lampIo <= ~pendIndex[4];
						end
						else
						begin
							comm_fault_lamp <= 1'b0;
							lampIo <= 1'b0;
							lampNode <= 4'h0;
						end
					end
					ST_SHOW:
					begin
						// other errors wait until this one clears
						if (!shownStillFaulty)
						begin
							state <= ST_IDLE;
							comm_fault_lamp <= 1'b0;
							lampIo <= 1'b0;
							lampNode <= 4'h0;
						end
						else
						begin
							lampNode <= shown[3:0];
							lampIo <= ~shown[4];
						end
					end
					default:
					begin
						state <= ST_IDLE;
						comm_fault_lamp <= 1'b0;
						lampIo <= 1'b0;
						lampNode <= 4'h0;
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

/* File: slave_error_status_reporter_assertions.sv */
// port assertions for the slave error status reporter
`timescale 1ns/1ps
`default_nettype none
module slave_error_status_reporter_chk (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic clockEnable,
	input wire logic restart,
	input wire logic wideModePin,
	input wire logic familyPin,
	input wire logic [3:0] unitNumberPin,
	input wire logic [15:0] outFault,
	input wire logic hostRead,
	input wire logic [15:0] hostReadData,
	input wire logic hostReadAck,
	input wire logic [11:0] statusBase,
	input wire logic unitValid,
	input wire logic comm_fault_lamp,
	input wire logic lampIo,
	input wire logic [3:0] lampNode
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	sequence s_pinsSteady;
		(clockEnable && $stable(familyPin) && $stable(wideModePin)
			&& $stable(unitNumberPin))[*5];
	endsequence
	property p_readAck;
		clockEnable |=> hostReadAck == $past(hostRead);
	endproperty
	a_readAck: assert property (p_readAck) else $error("read ack late");
	property p_readHold;
		!(clockEnable && (hostRead || restart)) |=> $stable(hostReadData);
	endproperty
	a_readHold: assert property (p_readHold) else $error("read data moved");
	property p_showHold;
		$past(comm_fault_lamp) && comm_fault_lamp |-> $stable({lampNode, lampIo});
	endproperty
	a_showHold: assert property (p_showHold) else $error("display moved");
	property p_idleDark;
		!comm_fault_lamp |-> lampNode == 4'h0 && !lampIo;
	endproperty
	a_idleDark: assert property (p_idleDark) else $error("lamps not off");
	property p_restartDark;
		clockEnable && restart |=> !comm_fault_lamp;
	endproperty
	a_restartDark: assert property (p_restartDark) else $error("lamp kept");
	property p_faultShown;
		clockEnable && !restart && !comm_fault_lamp && (|outFault[7:0])
			|-> ##[1:3] comm_fault_lamp;
	endproperty
	a_faultShown: assert property (p_faultShown) else $error("no lamp");
	property p_baseAddr;
		s_pinsSteady |-> !unitValid || statusBase == (!familyPin ?
			12'h7D0 + 12'h00A * unitNumberPin : unitNumberPin < 4'hA ?
			12'h064 + 12'h00A * unitNumberPin :
			12'h190 + 12'h00A * (unitNumberPin - 4'hA));
	endproperty
	a_baseAddr: assert property (p_baseAddr) else $error("bad base");
	property p_unitLegal;
		s_pinsSteady |-> unitValid == (!familyPin || !wideModePin
			|| (unitNumberPin != 4'h9 && unitNumberPin != 4'hF));
	endproperty
	a_unitLegal: assert property (p_unitLegal) else $error("bad unit");
	c_lampOn: cover property ($rose(comm_fault_lamp));
	c_readWord: cover property (hostReadAck && hostReadData != 16'h0000);
	c_restartLit: cover property (restart && comm_fault_lamp);
endmodule
bind slave_error_status_reporter slave_error_status_reporter_chk chk (
	.clock, .arst_n, .clockEnable, .restart, .wideModePin, .familyPin,
	.unitNumberPin, .outFault, .hostRead, .hostReadData, .hostReadAck,
	.statusBase, .unitValid, .comm_fault_lamp, .lampIo, .lampNode);
`default_nettype wire

/* File: slave_nodes_model.sv */
// behavioural model of the remote slave nodes
`timescale 1ns/1ps
`default_nettype none
module slave_nodes_model (
	input wire logic clock,
	output logic [15:0] outJoin,
	output logic [15:0] outFault,
	output logic [15:0] inJoin,
	output logic [15:0] inFault,
	output var logic rxStrobe,
	output var logic [3:0] rxNode,
	output var logic [7:0] rxData
);
	logic [63:0] events = 64'h0;
	assign {inFault, inJoin, outFault, outJoin} = events;
	initial
	begin
		rxStrobe = 1'b0;
		rxNode = 4'h0;
		rxData = 8'h00;
	end
	// one cycle of join and fault pulses, several nodes at once
	task automatic burst(input logic [63:0] v);
		@(posedge clock);
		events <= v;
		@(posedge clock);
		events <= 64'h0;
	endtask
	// one input frame; released lines carry inverted values
	task automatic send(input logic [3:0] node, input logic [7:0] data);
		@(posedge clock);
		rxStrobe <= 1'b1;
		rxNode <= node;
		rxData <= data;
		@(posedge clock);
		rxStrobe <= 1'b0;
		rxNode <= ~node;
		rxData <= ~data;
	endtask
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking testbench of the slave error status reporter
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	logic clockEnable = 1'b1;
	logic restart = 1'b0;
	logic wideModePin = 1'b0;
	logic familyPin = 1'b0;
	logic [3:0] unitNumberPin = 4'h0;
	logic [3:0] inputSelect = 4'h0;
	logic hostRead = 1'b0;
	logic [11:0] hostAddr = 12'h000;
	logic [15:0] outJoin, outFault, inJoin, inFault, hostReadData;
	logic rxStrobe, hostReadAck, unitValid, comm_fault_lamp, lampIo;
	logic [3:0] rxNode, lampNode;
	logic [7:0] rxData, selectedInput;
	logic [11:0] statusBase;
	logic [11:0] base = 12'h7DA;
	logic [18:0] rows [7];
	int n_fail = 0;
	int samples_checked = 0;
	always #20 clock = ~clock;
	slave_nodes_model nodes (.clock, .outJoin, .outFault, .inJoin, .inFault,
		.rxStrobe, .rxNode, .rxData);
	slave_error_status_reporter dut (.clock, .arst_n, .clockEnable, .restart,
		.wideModePin, .familyPin, .unitNumberPin, .outJoin, .outFault, .inJoin,
		.inFault, .rxStrobe, .rxNode, .rxData, .inputSelect, .selectedInput,
		.hostRead, .hostAddr, .hostReadData, .hostReadAck, .statusBase,
		.unitValid, .comm_fault_lamp, .lampIo, .lampNode);
	function automatic logic [63:0] ev(input logic [1:0] k, input logic [3:0] n);
		return 64'h1 << {k, n};
	endfunction
	task automatic chk(input string what, input logic [15:0] e, g);
		samples_checked++;
		if (g !== e)
		begin
			$display("Error %s expected %h seen %h", what, e, g);
			n_fail++;
		end
	endtask
	task automatic rd(input logic [11:0] ofs, input logic [15:0] e);
		@(posedge clock);
		hostRead <= 1'b1;
		hostAddr <= base + ofs;
		@(posedge clock);
		hostRead <= 1'b0;
		@(negedge clock);
		chk("ack", 16'h0001, {15'h0, hostReadAck});
		chk("word", e, hostReadData);
	endtask
	task automatic waitLamp(input logic level);
		for (int i = 0; i < 8 && comm_fault_lamp !== level; i++)
			@(negedge clock);
		chk("lamp", {15'h0, level}, {15'h0, comm_fault_lamp});
	endtask
	task automatic lamp(input logic io, input logic [3:0] node);
		waitLamp(1'b1);
		chk("lamps", {11'h0, io, node}, {11'h0, lampIo, lampNode});
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial
	begin
		rows = '{{2'b01, 4'hF, 12'h866, 1'b1}, {2'b10, 4'h9, 12'h0BE, 1'b1},
			{2'b10, 4'hA, 12'h190, 1'b1}, {2'b11, 4'h8, 12'h0B4, 1'b1},
			{2'b11, 4'h9, 12'h000, 1'b0}, {2'b11, 4'hE, 12'h1B8, 1'b1},
			{2'b11, 4'hF, 12'h000, 1'b0}};
		repeat (5) @(posedge clock);
		arst_n <= 1'b1;
		foreach (rows[i])
		begin
			{familyPin, wideModePin, unitNumberPin} <= rows[i][18:13];
			repeat (5) @(posedge clock);
			chk("valid", {15'h0, rows[i][0]}, {15'h0, unitValid});
			if (rows[i][0])
				chk("base", {4'h0, rows[i][12:1]}, {4'h0, statusBase});
		end
		{familyPin, wideModePin, unitNumberPin} <= 6'h01;
		repeat (5) @(posedge clock);
		chk("base", {4'h0, base}, {4'h0, statusBase});
		$display("table finished");
		rd(12'h008, 16'h0000);
		rd(12'h009, 16'h0000);
		waitLamp(1'b0);
		$display("reset test finished");
		nodes.burst(ev(0, 2) | ev(0, 9) | ev(2, 5));
		rd(12'h008, 16'h0004);
		rd(12'h009, 16'h0020);
		rd(12'h010, 16'h0000);
		nodes.burst(ev(1, 2));
		lamp(1'b1, 4'h2);
		rd(12'h008, 16'h0404);
		$display("narrow flags test finished");
		nodes.burst(ev(3, 7));
		repeat (3) @(posedge clock);
		lamp(1'b1, 4'h2);
		nodes.burst(ev(0, 2));
		waitLamp(1'b0);
		lamp(1'b0, 4'h7);
		rd(12'h009, 16'h8020);
		rd(12'h008, 16'h0004);
		nodes.burst(ev(2, 7));
		waitLamp(1'b0);
		@(posedge clock);
		inputSelect <= 4'h1;
		nodes.send(4'h1, 8'hA5);
		repeat (2) @(negedge clock);
		chk("held", 16'h00A5, {8'h0, selectedInput});
		nodes.burst(ev(1, 5) | ev(3, 1));
		lamp(1'b1, 4'h5);
		nodes.send(4'h1, 8'h5A);
		repeat (2) @(negedge clock);
		chk("held", 16'h00A5, {8'h0, selectedInput});
		$display("display order test finished");
		@(posedge clock);
		restart <= 1'b1;
		@(posedge clock);
		restart <= 1'b0;
		waitLamp(1'b0);
		rd(12'h008, 16'h0000);
		rd(12'h009, 16'h0000);
		$display("restart test finished");
		@(posedge clock);
		wideModePin <= 1'b1;
		repeat (5) @(posedge clock);
		nodes.burst(ev(0, 12) | ev(3, 9));
		lamp(1'b0, 4'h9);
		rd(12'h012, 16'h0010);
		rd(12'h013, 16'h0200);
		rd(12'h008, 16'h0000);
		rd(12'h000, 16'h0000);
		$display("wide flags test finished");
		// frozen clock enable: events of that time are lost
		@(posedge clock);
		clockEnable <= 1'b0;
		nodes.burst(ev(2, 9) | ev(1, 3));
		repeat (2) @(negedge clock);
		lamp(1'b0, 4'h9);
		@(posedge clock);
		clockEnable <= 1'b1;
		rd(12'h010, 16'h0000);
		rd(12'h013, 16'h0200);
		// reset in mid-run while the lamp is lit
		@(posedge clock);
		arst_n <= 1'b0;
		@(negedge clock);
		chk("lamp rst", 16'h0000, {15'h0, comm_fault_lamp});
		@(posedge clock);
		arst_n <= 1'b1;
		repeat (4) @(posedge clock);
		chk("base", {4'h0, base}, {4'h0, statusBase});
		rd(12'h013, 16'h0000);
		waitLamp(1'b0);
		$display("freeze and reset test finished");
		wrap_up;
	end
endmodule
`default_nettype wire
